// ---- pkg/dac_pkg.sv ----
// package: register map, field layout and types of the noise-shaped pwm dac
package dac_pkg;
  // byte addresses of the four word registers
  localparam logic [3:0] ADDR_CODE_LOW = 4'h0;
  localparam logic [3:0] ADDR_CODE_HIGH = 4'h4;
  localparam logic [3:0] ADDR_CFG0 = 4'h8;
  localparam logic [3:0] ADDR_CFG1 = 4'hc;
  localparam logic [3:0] ADDR_STATUS = 4'h0; // word index view, unused
  // cfg0 field positions
  localparam int ORDER_HI = 7;
  localparam int ORDER_LO = 6;
  localparam int WCODE_HI = 5;
  localparam int WCODE_LO = 3;
  localparam int EN_HI = 2;
  localparam int EN_LO = 1;
  localparam int HALVE_BIT = 0;
  // cfg1 field positions, then shared widths and constants
  localparam int BW_BIT = 1;
  localparam int INV_BIT = 0;
  localparam logic [3:0] MIN_WIDTH = 4'h4;
  localparam logic [1:0] ORDER0 = 2'h0;
  localparam logic [1:0] ORDER1 = 2'h1;
  localparam int CODE_W = 16;
  localparam int ACC_W = 20;
  localparam int MAXW = 11;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } av_req_t;

  typedef struct packed {
    bus_state_t bus;
    logic [31:0] rdata;
    logic waitreq;
    logic [7:0] code_low;
    logic [7:0] code_high;
    logic [15:0] code;
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic div_ph;
    logic [10:0] cnt;
    logic [10:0] duty;
    logic signed [ACC_W-1:0] acc1;
    logic signed [ACC_W-1:0] acc2;
    logic signed [ACC_W-1:0] err1;
    logic pwm;
    logic period_strobe;
  } dac_state_t;
endpackage

// ---- src/ns_pwm_dac.sv ----
// noise-shaped pwm dac core with avalon-mm register slave
`timescale 1ns/1ps
module ns_pwm_dac (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // avalon-mm slave
  input wire dac_pkg::av_req_t AV_REQ,
  output logic [31:0] AV_READDATA,
  output logic AV_WAITREQUEST,
  // dac outputs
  output logic PWM_OUT,
  output logic DAC_ENABLE,
  output logic AMP_ENABLE,
  output logic AMP_WIDE_BW
);
  import dac_pkg::*;

  dac_state_t s_r, s_nxt;

  // bus timing, as a master sees it:
  //   edge e   request taken while idle; the read word is latched here
  //   edge e+1 waitrequest sampled low; a write lands on this edge
  //   edge e+2 idle again, so the next request may be taken
  // writes wait for the acking edge, so a request that a low clock
  // enable stalls never changes a register ahead of its answer

  // modulator timing:
  //   one tick per clock, or one per second clock with the halve bit
  //   the count runs 0..2^m-1 and wraps; duty loads at the wrap, so a
  //   new code is heard from the next period on; a new width moves the wrap at once
  //   output is high while count < duty, then flipped by the invert bit
  //   code zero never goes high; the top code stays low for one tick

  // shaper:
  //   order 0 keeps the upper m bits and drops the rest
  //   order 1 carries the dropped bits into the next period
  //   order 2 feeds back 2e[n-1]-e[n-2]; codes and error are clamped,
  //   so codes close to either rail lose resolution
  //   all error state clears while the converter is disabled

  // width m from the three-bit code
  function automatic logic [3:0] width_of(input logic [7:0] cfg);
    width_of = MIN_WIDTH + {1'b0, cfg[WCODE_HI:WCODE_LO]};
  endfunction

  // all-ones mask of m bits: the largest pwm code
  function automatic logic [10:0] top_of(input logic [3:0] m);
    top_of = 11'((12'h001 << m) - 12'h001);
  endfunction

  // merge one written byte into a register
  function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                         input av_req_t q);
    wr_byte = q.byteenable[0] ? q.writedata[7:0] : old;
  endfunction

  // read mux: one byte per word, upper lanes read as zero
  function automatic logic [31:0] read_mux(input dac_state_t s,
                                           input logic [3:0] a);
    case (a)
      ADDR_CODE_LOW: read_mux = {24'h000000, s.code_low};
      ADDR_CODE_HIGH: read_mux = {24'h000000, s.code_high};
      ADDR_CFG0: read_mux = {24'h000000, s.cfg0};
      ADDR_CFG1: read_mux = {24'h000000, s.cfg1};
      default: read_mux = UNMAPPED_READ;
    endcase
  endfunction

  // commit one write; only ever applied on the acking edge
  function automatic dac_state_t commit_write(input dac_state_t s,
                                              input av_req_t q);
    commit_write = s;
    case (q.address)
      ADDR_CODE_LOW: commit_write.code_low = wr_byte(s.code_low, q);
      ADDR_CODE_HIGH: begin
        commit_write.code_high = wr_byte(s.code_high, q);
        // both bytes move together only here, so a lone low-byte
        // write cannot tear the code that the modulator sees
        if (q.byteenable[0]) begin
          commit_write.code = {q.writedata[7:0], s.code_low};
        end
      end
      ADDR_CFG0: commit_write.cfg0 = wr_byte(s.cfg0, q);
      ADDR_CFG1: commit_write.cfg1 = wr_byte(s.cfg1, q);
      default: ; // unmapped writes are dropped
    endcase
  endfunction

  // hold a shaped code inside the pwm range 0..top
  function automatic logic signed [ACC_W-1:0] clamp_code(
      input logic signed [ACC_W-1:0] v,
      input logic signed [ACC_W-1:0] hi);
    if (v < 0) begin
      clamp_code = '0;
    end else if (v > hi) begin
      clamp_code = hi;
    end else begin
      clamp_code = v;
    end
  endfunction

  // limit the error state to one pwm step either way, so a long run
  // in saturation cannot wind the loop up
  function automatic logic signed [ACC_W-1:0] bound_err(
      input logic signed [ACC_W-1:0] e,
      input logic [3:0] lsb_sh);
    logic signed [ACC_W-1:0] lim;
    lim = ACC_W'(1) <<< lsb_sh;
    if (e > lim) begin
      bound_err = lim;
    end else if (e < -lim) begin
      bound_err = -lim;
    end else begin
      bound_err = e;
    end
  endfunction

  logic [3:0] m;
  logic [10:0] top;
  logic [3:0] sh;
  logic signed [ACC_W-1:0] in_full;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] q_val;
  logic signed [ACC_W-1:0] q_code;
  logic signed [ACC_W-1:0] top_s;
  logic tick;
  logic wrap;
  logic [1:0] order;

  always_comb begin
    s_nxt = s_r;
    m = width_of(s_r.cfg0);
    top = top_of(m);
    sh = 4'(CODE_W) - m;
    order = s_r.cfg0[ORDER_HI:ORDER_LO];
    in_full = ACC_W'(s_r.code);
    top_s = ACC_W'(top);
    sum = '0;
    q_val = '0;
    q_code = '0;
    tick = 1'b0;
    wrap = 1'b0;
    s_nxt.period_strobe = 1'b0;

    // bus slave: one wait cycle, then answer with waitrequest low
    case (s_r.bus)
      ST_IDLE: begin
        s_nxt.waitreq = 1'b1;
        if (AV_REQ.read || AV_REQ.write) begin
          s_nxt.bus = ST_ACK;
          s_nxt.waitreq = 1'b0;
          if (AV_REQ.read) begin
            s_nxt.rdata = read_mux(s_r, AV_REQ.address);
          end
        end
      end
      ST_ACK: begin
        // request still held here; the write lands on this edge
        if (AV_REQ.write) begin
          s_nxt = commit_write(s_nxt, AV_REQ);
        end
        s_nxt.bus = ST_IDLE;
        s_nxt.waitreq = 1'b1;
      end
      default: begin
        s_nxt.bus = ST_IDLE;
        s_nxt.waitreq = 1'b1;
      end
    endcase

    // modulator clock: every cycle, or every second one when halved
    if (s_r.cfg0[HALVE_BIT]) begin
      s_nxt.div_ph = ~s_r.div_ph;
      tick = s_r.div_ph;
    end else begin
      s_nxt.div_ph = 1'b0;
      tick = 1'b1;
    end

    // period counter over 2^m modulator clocks
    if (s_r.cfg0[EN_LO] && tick) begin
      wrap = (s_r.cnt >= top);
      s_nxt.cnt = wrap ? 11'h000 : s_r.cnt + 11'h001;
    end else if (!s_r.cfg0[EN_LO]) begin
      s_nxt.cnt = 11'h000;
      s_nxt.acc1 = '0;
      s_nxt.acc2 = '0;
      s_nxt.err1 = '0;
    end

    // new duty at each period start; shaper runs once per period
    if (wrap) begin
      s_nxt.period_strobe = 1'b1;
      if (order == ORDER0) begin
        s_nxt.duty = 11'(s_r.code >> sh);
      end else if (order == ORDER1) begin
        // first order: carry the truncation error forward
        sum = in_full + s_r.acc1;
        q_val = sum >>> sh;
        s_nxt.acc1 = sum - (q_val <<< sh);
        // a carry can reach 2^m; the pwm cannot show it
        q_val = clamp_code(q_val, top_s);
        s_nxt.duty = 11'(q_val);
      end else begin
        // second order: error filter 2e[n-1]-e[n-2] added to input
        sum = in_full + (s_r.acc1 <<< 1) - s_r.acc2;
        q_val = sum >>> sh;
        q_code = clamp_code(q_val, top_s);
        // error is vs the saturated code, so extremes dither less
        s_nxt.acc2 = s_r.acc1;
        s_nxt.acc1 = sum - (q_code <<< sh);
        // bound the loop so saturation cannot wind it up
        s_nxt.acc1 = bound_err(s_nxt.acc1, sh);
        s_nxt.duty = 11'(q_code);
      end
    end

    // high while count is below duty: code 0 never high, top gives top/2^m
    s_nxt.pwm = s_r.cfg0[EN_LO] && (s_nxt.cnt < s_nxt.duty);
    s_nxt.pwm = s_nxt.pwm ^ s_r.cfg1[INV_BIT];
  end

  // single state register; clock enable freezes everything
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_r <= '{bus: ST_IDLE, waitreq: 1'b1, default: '0};
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  assign AV_READDATA = s_r.rdata;
  assign AV_WAITREQUEST = s_r.waitreq;
  assign PWM_OUT = s_r.pwm;
  assign DAC_ENABLE = s_r.cfg0[EN_LO];
  assign AMP_ENABLE = s_r.cfg0[EN_HI];
  assign AMP_WIDE_BW = s_r.cfg1[BW_BIT];
endmodule // ns_pwm_dac

// ---- verif/ns_pwm_dac_properties.sv ----
// checker on the ports of the dac core
`timescale 1ns/1ps
module dac_checker (
  // clock and control
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // bus and outputs
  input wire dac_pkg::av_req_t AV_REQ,
  input wire logic [31:0] AV_READDATA,
  input wire logic AV_WAITREQUEST,
  input wire logic PWM_OUT,
  input wire logic DAC_ENABLE,
  input wire logic AMP_ENABLE,
  input wire logic AMP_WIDE_BW
);
  import dac_pkg::*;
  logic tk, wr;
  logic [2:0] lv;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // accepted request, lane-0 write and the level outputs
  assign tk = (AV_REQ.read | AV_REQ.write) & AV_WAITREQUEST & CE;
  assign wr = tk & AV_REQ.write & AV_REQ.byteenable[0];
  assign lv = {AMP_WIDE_BW, AMP_ENABLE, DAC_ENABLE};
  a_req_answer: assert property (tk |=> !AV_WAITREQUEST) else $error("no ack");
  a_ack_once: assert property (!AV_WAITREQUEST && CE |=> AV_WAITREQUEST)
    else $error("long ack");
  a_ack_cause: assert property ($fell(AV_WAITREQUEST) |-> $past(tk))
    else $error("stray ack");
  a_read_narrow: assert property (!AV_WAITREQUEST |-> AV_READDATA[31:8] == 0)
    else $error("wide read");
  a_cfg0_out: assert property (wr && AV_REQ.address == ADDR_CFG0 |=> ##1
    lv[1:0] == $past(AV_REQ.writedata[2:1], 2)) else $error("bad enables");
  a_cfg1_out: assert property (wr && AV_REQ.address == ADDR_CFG1 |=> ##1
    lv[2] == $past(AV_REQ.writedata[1], 2)) else $error("bad bandwidth");
  a_lane_off: assert property (tk && AV_REQ.write && !AV_REQ.byteenable[0]
    |=> ##1 lv == $past(lv, 2)) else $error("masked write took");
  a_ce_hold: assert property (!CE |=> $stable(PWM_OUT)) else $error("ran");
endmodule // dac_checker
bind ns_pwm_dac dac_checker i_chk (.CLK(CLK), .RST(RST), .CE(CE),
  .AV_REQ(AV_REQ), .AV_READDATA(AV_READDATA),
  .AV_WAITREQUEST(AV_WAITREQUEST), .PWM_OUT(PWM_OUT),
  .DAC_ENABLE(DAC_ENABLE), .AMP_ENABLE(AMP_ENABLE), .AMP_WIDE_BW(AMP_WIDE_BW));

// ---- verif/ns_pwm_dac_tb.sv ----
// bench for the dac core
`timescale 1ns/1ps
module ns_pwm_dac_tb;
  import dac_pkg::*;
  typedef struct {logic [7:0] c0, c1; logic [15:0] cd; int per, hi;} row_t;
  // cfg0, cfg1, code, periods counted, high cycles expected
  row_t rows [8] = '{
    '{8'h02, 8'h00, 16'h0000, 2, 0}, '{8'h02, 8'h00, 16'hffff, 2, 30},
    '{8'h3f, 8'h02, 16'h1234, 2, 580}, '{8'h1a, 8'h01, 16'habcd, 2, 86},
    '{8'h42, 8'h00, 16'h5400, 64, 336}, '{8'h82, 8'h00, 16'h5400, 64, 336},
    '{8'hca, 8'h00, 16'h5400, 64, 672}, '{8'h82, 8'h00, 16'hffff, 64, 960}};
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wq, pwm, den, aen, bw;
  av_req_t req = '0;
  logic [31:0] rd, q;
  int errors = 0, compares = 0, n, p;
  ns_pwm_dac i_dut (.CLK(clk), .RST(rst), .CE(ce), .AV_REQ(req),
    .AV_READDATA(rd), .AV_WAITREQUEST(wq), .PWM_OUT(pwm), .DAC_ENABLE(den),
    .AMP_ENABLE(aen), .AMP_WIDE_BW(bw));
  // 100 mhz clock
  initial forever #5 clk = ~clk;
  task automatic finish_test;
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  // one transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v,
    input logic [3:0] be = 4'h1);
    int i;
    @(posedge clk);
    req <= '{a, !w, w, {24'h0, v}, be};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wq !== 1'b0 && i < 50);
    if (wq !== 1'b0) begin
      errors++;
      finish_test();
    end
    q = rd;
    req <= '0;
  endtask
  // settle four periods first, since new codes load only at a wrap
  task automatic meas(input int k);
    n = 0;
    repeat (4 * p) @(negedge clk);
    repeat (k * p) begin
      @(negedge clk);
      n += (pwm === 1'b1);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k]) begin
      bus(1, ADDR_CFG1, rows[k].c1);
      bus(1, ADDR_CODE_LOW, rows[k].cd[7:0]);
      bus(1, ADDR_CODE_HIGH, rows[k].cd[15:8]);
      bus(1, ADDR_CFG0, rows[k].c0);
      bus(0, ADDR_CFG0, 8'h00);
      chk(q, rows[k].c0);
      chk({bw, aen, den}, {rows[k].c1[1], rows[k].c0[2:1]});
      p = (16 << rows[k].c0[5:3]) * (1 + rows[k].c0[0]);
      meas(rows[k].per);
      n = (n - rows[k].hi) ** 2;
      chk(n <= (rows[k].per > 2 ? 16 : 0), 1);
    end
    // low byte alone must not reach the modulator
    p = 2048;
    bus(1, ADDR_CFG0, 8'h3a);
    bus(1, ADDR_CODE_LOW, 8'h00);
    bus(1, ADDR_CODE_HIGH, 8'h10);
    bus(1, ADDR_CODE_LOW, 8'he0);
    meas(1);
    chk(n, 128);
    bus(1, ADDR_CODE_HIGH, 8'h10);
    meas(1);
    chk(n, 135);
    // masked lane, unmapped place, frozen clock enable
    bus(1, ADDR_CFG0, 8'h00, 4'h0);
    bus(0, ADDR_CFG0, 8'h00);
    chk(q, 8'h3a);
    bus(0, 4'h2, 8'h00);
    chk(q, 0);
    p = 25;
    @(posedge clk) ce <= 1'b0;
    meas(1);
    chk(n % 25, 0);
    // second reset clears every register
    @(posedge clk) ce <= 1'b1;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk({pwm, den, wq}, 3'b001);
    for (int a = 0; a < 16; a += 4) begin
      bus(0, 4'(a), 8'h00);
      chk(q, 0);
    end
    finish_test();
  end
endmodule // ns_pwm_dac_tb
